// File: src/vpic_ctrl.sv
// Function
// - Each source has a request flag, set by hardware, cleared by software write.
// - Each source has an enable bit; disabled sources never request the core.
// - Each user source has a 3-bit programmable priority, eight levels.
// - Pending vector (7 bits) and new level (4 bits) latched in readable register.
// - Latched new level equals the programmed priority of the presented interrupt.
// - Flag, enable, priority positions follow vector-list order; source 0 at bit 0.
// - Vector address is 0x14 plus twice vector; alternate table adds 0x100.
// - External interrupt zero is vector 0 with highest natural rank.
// - Second global control selects alternate table and external input behaviour.
// - First global control holds nesting disable and the trap status flags.
// - Low three level bits sit at status word bits 7:5, software writable.
// - Top level bit in core control is read-only and completes the 4-bit level.
// - Codes 0..7 mean levels 0..7 or 8..15; level 7 up masks user sources.
// - With nesting disable set, the status word level bits are read-only.
// - Status word bits 15 to 9 read as zero.
// - Equal priority resolves to the lower vector number.
`include "vpic_consts.svh"

module vpic_ctrl
  import vpic_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire bus_req_t         bus_req,
  output bus_rsp_t              bus_rsp,
  input  wire logic [7:0]       src_event,
  input  wire logic             ext_irq_zero,
  input  wire logic [3:0]       trap_event,
  input  wire logic             trap_enter,
  input  wire logic             trap_return,
  input  wire logic             core_ack,
  output core_req_t             core_req,
  output logic                  irq
);

  localparam logic [6:0] VEC_TABLE [`NUM_SRC] = '{7'h00, 7'h02, 7'h03, 7'h06,
                                                 7'h07, 7'h08, 7'h0b, 7'h0c};

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic [7:0]  cand;
  logic        any;
  logic [2:0]  win_idx;
  logic [2:0]  win_prio;
  logic [3:0]  cur_lvl;
  logic        ext_edge;
  logic [7:0]  hw_set;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic        wr_now;
  logic        rd_first;
  logic [31:0] rd_val;
  logic [31:0] sw_word;
  logic [23:0] vec_addr;

  assign cur_lvl = {s.lvl_top, s.lvl_low};

  // Candidate sources
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++)
    begin : g_cand
      assign cand[g] = s.flags[g] && s.enable[g]
                       && ({1'b0, s.prio[g*`PRIO_STRIDE +: `PRIO_W]} > cur_lvl);
    end
  endgenerate

  vpic_arbiter u_arb (
    .cand     (cand),
    .prio     (s.prio),
    .any      (any),
    .win_idx  (win_idx),
    .win_prio (win_prio)
  );

  // External pin edge, polarity from second global control
  assign ext_edge = s.ext_fall ? (s.ext_prev && !ext_irq_zero)
                               : (!s.ext_prev && ext_irq_zero);
  assign hw_set   = src_event | {7'h00, ext_edge};

  assign wmask    = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
                     {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};
  assign wd       = bus_req.writedata & wmask;
  assign wr_now   = bus_req.write && s.done;
  assign rd_first = bus_req.read && !s.done;

  assign sw_word  = {16'h0000, 8'h00, s.lvl_low, 5'h00};

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (bus_req.address)
      `OFF_FLAGS:       rd_val = {24'h0, s.flags};
      `OFF_ENABLE:      rd_val = {24'h0, s.enable};
      `OFF_PRIO:        rd_val = s.prio;
      `OFF_GCTRL1:      rd_val = {16'h0, s.nest_dis, 10'h0, s.trap_flags, 1'b0};
      `OFF_GCTRL2:      rd_val = {16'h0, s.alt_table, 14'h0, s.ext_fall};
      `OFF_PENDING:     rd_val = {20'h0, s.pend_lvl, 1'b0, s.pend_vec};
      `OFF_STATUS_WORD: rd_val = sw_word;
      `OFF_CORE_CTRL:   rd_val = {28'h0, s.lvl_top, 3'h0};
      `OFF_IRQ_STATUS:  rd_val = {30'h0, s.ev_status};
      `OFF_IRQ_MASK:    rd_val = {30'h0, s.ev_mask};
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  assign vec_addr = `VEC_BASE + {16'h0000, s.pend_vec, 1'b0}
                    + (s.alt_table ? `ALT_OFFSET : 24'h000000);

  always_comb
  begin
    next_s          = s;
    next_s.ext_prev = ext_irq_zero;

    // One wait cycle per access; read data captured in the first cycle
    next_s.done = (bus_req.read || bus_req.write) && !s.done;
    if (rd_first)
    begin
      next_s.rdata = rd_val;
    end

    if (wr_now)
    begin
      case (bus_req.address)
        `OFF_FLAGS:
        begin
          next_s.flags = s.flags & ~wd[7:0];
        end
        `OFF_ENABLE:
        begin
          next_s.enable = (s.enable & ~wmask[7:0]) | wd[7:0];
        end
        `OFF_PRIO:
        begin
          next_s.prio = (s.prio & ~wmask) | (wd & 32'h7777_7777);
        end
        `OFF_GCTRL1:
        begin
          if (wmask[`NEST_DIS_BIT])
          begin
            next_s.nest_dis = wd[`NEST_DIS_BIT];
          end
          if (wmask[`TRAP_LO])
          begin
            next_s.trap_flags = wd[`TRAP_HI:`TRAP_LO];
          end
        end
        `OFF_GCTRL2:
        begin
          if (wmask[`ALT_TABLE_BIT])
          begin
            next_s.alt_table = wd[`ALT_TABLE_BIT];
          end
          if (wmask[`EXT_FALL_BIT])
          begin
            next_s.ext_fall = wd[`EXT_FALL_BIT];
          end
        end
        `OFF_STATUS_WORD:
        begin
          if (wmask[`SW_LVL_LO] && !s.nest_dis)
          begin
            next_s.lvl_low = wd[`SW_LVL_HI:`SW_LVL_LO];
          end
        end
        `OFF_IRQ_STATUS:
        begin
          next_s.ev_status = s.ev_status & ~wd[`EV_W-1:0];
        end
        `OFF_IRQ_MASK:
        begin
          next_s.ev_mask = wd[`EV_W-1:0];
        end
        default:
        begin
          next_s.done = 1'b0;
        end
      endcase
    end

    // Hardware sets win over software clears
    next_s.flags      = next_s.flags | hw_set;
    next_s.trap_flags = next_s.trap_flags | trap_event;

    // Latch the winner while one exists
    next_s.req = any;
    if (any)
    begin
      next_s.pend_vec = VEC_TABLE[win_idx];
      next_s.pend_lvl = {1'b0, win_prio};
    end

    // Core takes the interrupt: raise level to the presented one
    if (core_ack && s.req)
    begin
      next_s.lvl_low = s.pend_lvl[2:0];
    end
    if (trap_enter)
    begin
      next_s.lvl_top = 1'b1;
    end
    else if (trap_return)
    begin
      next_s.lvl_top = 1'b0;
    end

    if (any && !s.req)
    begin
      next_s.ev_status[`EV_REQ_BIT] = 1'b1;
    end
    if (|trap_event)
    begin
      next_s.ev_status[`EV_TRAP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bus_rsp.waitrequest = (bus_req.read || bus_req.write) && !s.done;
  assign bus_rsp.readdata    = s.rdata;

  assign core_req.valid  = s.req;
  assign core_req.vector = s.pend_vec;
  assign core_req.level  = s.pend_lvl;
  assign core_req.addr   = vec_addr;

  assign irq = |(s.ev_status & s.ev_mask);

endmodule // vpic_ctrl

// File: src/vpic_consts.svh
`ifndef VPIC_CONSTS_SVH
`define VPIC_CONSTS_SVH

`define NUM_SRC          8
`define ADDR_W           6
// Byte addresses of the word registers
`define OFF_FLAGS        6'h00
`define OFF_ENABLE       6'h04
`define OFF_PRIO         6'h08
`define OFF_GCTRL1       6'h0c
`define OFF_GCTRL2       6'h10
`define OFF_PENDING      6'h14
`define OFF_STATUS_WORD  6'h18
`define OFF_CORE_CTRL    6'h1c
`define OFF_IRQ_STATUS   6'h20
`define OFF_IRQ_MASK     6'h24
// Field positions
`define NEST_DIS_BIT     15
`define TRAP_LO          1
`define TRAP_HI          4
`define ALT_TABLE_BIT    15
`define EXT_FALL_BIT     0
`define VEC_LO           0
`define VEC_HI           6
`define LVL_LO           8
`define LVL_HI           11
`define SW_LVL_LO        5
`define SW_LVL_HI        7
`define TOP_BIT_POS      3
`define PRIO_STRIDE      4
`define PRIO_W           3
// Vector table geometry
`define VEC_BASE         24'h000014
`define ALT_OFFSET       24'h000100
// Vector numbers of the sources, in vector-list order
`define SRC_VECTORS      {7'h0c, 7'h0b, 7'h08, 7'h07, 7'h06, 7'h03, 7'h02, 7'h00}
// Host interrupt status bits
`define EV_REQ_BIT       0
`define EV_TRAP_BIT      1
`define EV_W             2

`endif

// File: src/vpic_pkg.sv
`include "vpic_consts.svh"

package vpic_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } bus_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  vector;
    logic [3:0]  level;
    logic [23:0] addr;
  } core_req_t;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  enable;
    logic [31:0] prio;
    logic        nest_dis;
    logic [3:0]  trap_flags;
    logic        alt_table;
    logic        ext_fall;
    logic [6:0]  pend_vec;
    logic [3:0]  pend_lvl;
    logic        req;
    logic [2:0]  lvl_low;
    logic        lvl_top;
    logic [1:0]  ev_status;
    logic [1:0]  ev_mask;
    logic        ext_prev;
    logic        done;
    logic [31:0] rdata;
  } ctrl_state_t;

endpackage

// File: src/vpic_arbiter.sv
`include "vpic_consts.svh"

module vpic_arbiter
  import vpic_pkg::*;
(
  input  wire logic [7:0]  cand,
  input  wire logic [31:0] prio,
  output logic             any,
  output logic [2:0]       win_idx,
  output logic [2:0]       win_prio
);

  always_comb
  begin
    any      = 1'b0;
    win_idx  = 3'h0;
    win_prio = 3'h0;
    // Highest index first so that a lower index wins ties
    for (int i = `NUM_SRC - 1; i >= 0; i--)
    begin
      if (cand[i] && (!any || prio[i*`PRIO_STRIDE +: `PRIO_W] >= win_prio))
      begin
        any      = 1'b1;
        win_idx  = 3'(i);
        win_prio = prio[i*`PRIO_STRIDE +: `PRIO_W];
      end
    end
  end

endmodule // vpic_arbiter

// File: testbench/vpic_asserts.sv
`include "vpic_consts.svh"
module vpic_asserts
  import vpic_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire bus_req_t   bus_req,
  input wire bus_rsp_t   bus_rsp,
  input wire logic [7:0] src_event,
  input wire logic       ext_irq_zero,
  input wire logic [3:0] trap_event,
  input wire logic       trap_enter,
  input wire logic       trap_return,
  input wire logic       core_ack,
  input wire core_req_t  core_req,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] rdat;
  logic        fin;
  assign rdat = bus_rsp.readdata;
  assign fin = bus_req.read & ~bus_rsp.waitrequest;
  property p_rst;
    $fell(rst) |-> !core_req.valid && !irq && core_req.addr == `VEC_BASE;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_wait;
    (bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("long wait");
  property p_addr;
    core_req.valid |-> (core_req.addr & ~`ALT_OFFSET) == `VEC_BASE + {16'h0, core_req.vector, 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("vector address");
  property p_vec;
    core_req.valid |-> core_req.vector inside {0, 2, 3, 6, 7, 8, 11, 12};
  endproperty
  a_vec: assert property (p_vec) else $error("vector number");
  property p_lvl;
    core_req.valid |-> core_req.level inside {[4'h1:4'h7]};
  endproperty
  a_lvl: assert property (p_lvl) else $error("request level");
  property p_sw;
    fin && bus_req.address == `OFF_STATUS_WORD |-> rdat[31:8] == 0 && rdat[4:0] == 0;
  endproperty
  a_sw: assert property (p_sw) else $error("status word bits");
  property p_cc;
    fin && bus_req.address == `OFF_CORE_CTRL |-> rdat[31:4] == 0 && rdat[2:0] == 0;
  endproperty
  a_cc: assert property (p_cc) else $error("core control bits");
  property p_pend;
    fin && bus_req.address == `OFF_PENDING |-> rdat[31:11] == 0 && !rdat[7];
  endproperty
  a_pend: assert property (p_pend) else $error("pending fields");
  c_ack: cover property (core_ack && core_req.valid);
  c_irq: cover property ($rose(irq));
  c_alt: cover property (core_req.valid && core_req.addr[8]);
endmodule // vpic_asserts

bind vpic_ctrl vpic_asserts u_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .src_event(src_event), .ext_irq_zero(ext_irq_zero),
  .trap_event(trap_event), .trap_enter(trap_enter), .trap_return(trap_return),
  .core_ack(core_ack), .core_req(core_req), .irq(irq));

// File: testbench/vpic_core_model.sv
module vpic_core_model
  import vpic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire core_req_t  core_req,
  input  wire logic       go,
  input  wire logic [1:0] dly,
  output logic            core_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  // Accepts a presented request after dly+2 cycles, never twice running
  always_ff @(posedge clk)
  begin
    if (rst || core_ack || !core_req.valid || !go)
    begin
      cnt <= 3'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      core_ack <= cnt == {1'b0, dly} + 3'h1;
    end
  end
endmodule // vpic_core_model

// File: testbench/testbench.sv
`include "vpic_consts.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench
  import vpic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, trap_enter = 0, go = 0, core_ack, irq, ext_pin = 0;
  logic [3:0]  trap_ev = 0;
  logic [1:0]  dly = 0;
  logic [2:0]  r;
  logic [7:0]  src_event = 0;
  logic [31:0] e, rd_q[$];
  logic [34:0] ec, core_q[$];
  bus_req_t    bus_req = '0;
  bus_rsp_t    bus_rsp;
  core_req_t   core_req;
  int          bad_count = 0, checks = 0, cyc = 0;
  vpic_ctrl uut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .src_event(src_event), .ext_irq_zero(ext_pin), .trap_event(trap_ev),
    .trap_enter(trap_enter), .trap_return(1'b0), .core_ack(core_ack),
    .core_req(core_req), .irq(irq));
  vpic_core_model core (.clk(clk), .rst(rst), .core_req(core_req), .go(go),
    .dly(dly), .core_ack(core_ack));
  initial forever #20 clk = ~clk;
  // Sampled at the edge the slave samples, before that edge's updates land
  always @(posedge clk)
  begin
    if (bus_req.read && !bus_rsp.waitrequest)
    begin
      e = rd_q.pop_front();
      `CHK("readdata", e, bus_rsp.readdata)
    end
    if (core_ack && core_req.valid)
    begin
      ec = core_q.pop_front();
      `CHK("core_req", ec, {core_req.addr, core_req.level, core_req.vector})
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: d};
    do @(posedge clk); while (bus_rsp.waitrequest);
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    acc(0, a, 0);
  endtask
  task see(input logic x, input logic v);
    repeat (2) @(negedge clk);
    `CHK("output", x, v ? irq : core_req.valid)
  endtask
  task pulse(input logic [7:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= 8'h00;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(47570));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 'h28; a += 4)
      rd(6'(a), 32'h0);
    $display("end reset");
    acc(1, `OFF_IRQ_MASK, 32'h1);
    acc(1, `OFF_ENABLE, 32'h2);
    acc(1, `OFF_PRIO, 32'h50);
    core_q.push_back({24'h000018, 4'h5, 7'h02});
    go <= 1'b1;
    pulse(8'h02);
    see(1'b1, 1'b1);
    rd(`OFF_STATUS_WORD, 32'ha0);
    rd(`OFF_PENDING, 32'h502);
    acc(1, `OFF_IRQ_STATUS, 32'h3);
    see(1'b0, 1'b1);
    go <= 1'b0;
    acc(1, `OFF_FLAGS, 32'hff);
    acc(1, `OFF_STATUS_WORD, 32'h0);
    $display("end request");
    r = 3'($urandom_range(7, 1));
    acc(1, `OFF_ENABLE, 32'hff);
    acc(1, `OFF_PRIO, {8{1'b0, r}});
    pulse(8'hff);
    rd(`OFF_PENDING, {21'h0, r, 8'h00});
    acc(1, `OFF_FLAGS, 32'h1);
    rd(`OFF_PENDING, {21'h0, r, 8'h02});
    acc(1, `OFF_ENABLE, 32'hfd);
    rd(`OFF_PENDING, {21'h0, r, 8'h03});
    $display("end order");
    acc(1, `OFF_STATUS_WORD, 32'he0);
    see(1'b0, 1'b0);
    acc(1, `OFF_GCTRL1, 32'h8000);
    acc(1, `OFF_STATUS_WORD, 32'h0);
    rd(`OFF_STATUS_WORD, 32'he0);
    rd(`OFF_GCTRL1, 32'h8000);
    acc(1, `OFF_GCTRL1, 32'h0);
    acc(1, `OFF_STATUS_WORD, 32'h0);
    $display("end level");
    acc(1, `OFF_GCTRL2, 32'h8000);
    core_q.push_back({24'h00011a, 1'b0, r, 7'h03});
    dly <= 2'h2;
    go <= 1'b1;
    pulse(8'h00);
    go <= 1'b0;
    $display("end table");
    trap_enter <= 1'b1;
    @(posedge clk);
    trap_enter <= 1'b0;
    rd(`OFF_CORE_CTRL, 32'h8);
    acc(1, `OFF_CORE_CTRL, 32'h0);
    rd(`OFF_CORE_CTRL, 32'h8);
    $display("end trap");
    ext_pin <= 1'b1;
    trap_ev <= 4'h5;
    @(posedge clk);
    trap_ev <= 4'h0;
    rd(`OFF_FLAGS, 32'hff);
    rd(`OFF_GCTRL1, 32'ha);
    $display("end pins");
    print_verdict();
  end
endmodule // testbench
